// [logic/tws_params.svh]
// Purpose: Constants of the two-wire control slave
// Assumes: Included by the design files by bare name
// Notes: Definitions only
`ifndef TWS_PARAMS_SVH
`define TWS_PARAMS_SVH

// Fixed upper five bits of the seven-bit slave address
`define TWS_ADDR_HI 5'h15
// Block pointer values
`define TWS_BLK_CTRL 8'h00
`define TWS_BLK_TABLE 8'h01
// Highest control register address; the pointer sticks here
`define TWS_CTRL_MAX 8'h4C
// Bit counter value of the eighth bit of a byte
`define TWS_LAST_BIT 3'h7
// Colour component index of the red-difference byte
`define TWS_LAST_COLOR 2'h2
// Position of a byte inside a write transaction
`define TWS_IDX_ADDR 2'h0
`define TWS_IDX_BLK 2'h1
`define TWS_IDX_OFS 2'h2
`define TWS_IDX_DATA 2'h3
// Idle level of synchronised inputs: lines high, port deselected
`define TWS_SYNC_IDLE 5'h1F

`endif

// [logic/tws_pkg.sv]
// Purpose: Types of the two-wire control slave
// Assumes: Nothing
// Notes: Constants live in tws_params.svh
package tws_pkg;

    typedef enum logic [2:0]
    {
        TWS_IDLE = 3'b000,
        TWS_RECV = 3'b001,
        TWS_ACK = 3'b010,
        TWS_SEND = 3'b011,
        TWS_MACK = 3'b100,
        TWS_SKIP = 3'b101
    } tws_state_e;

    typedef logic [7:0] tws_byte_t;

endpackage

// [logic/tws_slave.sv]
// Purpose: Two-wire serial slave giving access to control registers
//          and the overlay colour table
// Assumes: clk far faster than SCL; reg_rd_data valid one cycle after
//          reg_rd_en and held until the next reg_rd_en
// Notes on behaviour
// - Serial port works only while port_sel_n is low.
// - Slave address is 10101 followed by the two address select pins.
// - SDA changes during SCL high are start or stop conditions.
// - Start is SDA falling while SCL is high.
// - Stop is SDA rising while SCL is high; it ends writes.
// - First byte is seven address bits then direction, high means read.
// - Matching address is acknowledged on pulse nine; mismatch is ignored.
// - Every byte moves most significant bit first.
// - Without acknowledge the device leaves SDA released high.
// - Master not acknowledging a read byte ends the read.
// - Write sends block pointer then offset; 00 registers, 01 table.
// - Offset is the base address; first data byte goes there.
// - Control register writes advance the address after every byte.
// - Table writes take luma, blue, red, then advance the location.
// - Reads start at the base address and advance after each byte.
// - Repeated start restarts address decoding.
// - Device only pulls SDA low for acks and read data; never SCL.
// - Control register address stops at its maximum value.
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_slave
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Straps
    input wire logic port_sel_n,
    input wire logic [1:0] address_select_pins,
    // Register and table access
    output logic reg_wr_en,
    output logic reg_rd_en,
    output logic reg_block,
    output logic [7:0] reg_addr,
    output logic [1:0] color_sel,
    output logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data
);
    tws_sync_if sync_bus();

    // Pins are synchronised before any logic looks at them
    tws_sync u_sync
    (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl_pin(scl_in),
        .sda_pin(sda_in),
        .port_sel_n_pin(port_sel_n),
        .addr_sel_pin(address_select_pins),
        .sync(sync_bus)
    );

    tws_state_e state_q;
    logic scl_p_q;
    logic sda_p_q;
    logic [2:0] bit_cnt_q;
    logic byte_full_q;
    logic [1:0] byte_idx_q;
    logic dir_q;
    tws_byte_t rx_q;
    tws_byte_t tx_q;
    tws_byte_t blk_q;
    tws_byte_t ptr_q;
    logic [1:0] color_q;
    logic adv_q;
    logic load_q;
    logic sda_oe_n_q;
    logic reg_wr_en_q;
    logic reg_rd_en_q;
    tws_byte_t reg_wr_data_q;

    logic active;
    logic scl_rise;
    logic scl_fall;
    logic start_det;
    logic stop_det;
    logic byte_end;
    logic is_addr;
    logic addr_match;
    logic block_ok;
    logic tx_last;
    logic mack_ok;
    logic rd_first;
    logic wr_data;

    assign active = ~sync_bus.port_sel_n;
    assign scl_rise = sync_bus.scl & ~scl_p_q;
    assign scl_fall = ~sync_bus.scl & scl_p_q;
    // Conditions need SCL high in both samples around the SDA change
    assign start_det = sync_bus.scl & scl_p_q & sda_p_q
        & ~sync_bus.sda;
    assign stop_det = sync_bus.scl & scl_p_q & ~sda_p_q
        & sync_bus.sda;
    assign byte_end = (state_q == TWS_RECV) & scl_fall & byte_full_q;
    assign is_addr = (byte_idx_q == `TWS_IDX_ADDR);
    assign addr_match = (rx_q[7:1]
        == {`TWS_ADDR_HI, sync_bus.addr_sel});
    assign block_ok = (blk_q == `TWS_BLK_CTRL)
        | (blk_q == `TWS_BLK_TABLE);
    assign tx_last = (state_q == TWS_SEND) & scl_fall
        & (bit_cnt_q == `TWS_LAST_BIT);
    assign mack_ok = (state_q == TWS_MACK) & scl_rise & ~sync_bus.sda
        & ~start_det & ~stop_det;
    assign rd_first = byte_end & is_addr & addr_match & rx_q[0];
    assign wr_data = byte_end & ~dir_q
        & (byte_idx_q == `TWS_IDX_DATA);

    // Previous synchronised samples for edge detection
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            scl_p_q <= sync_bus.scl;
            sda_p_q <= sync_bus.sda;
        end
    end

    // Transaction sequencing
    always_ff @(posedge clk)
    begin
        if (sys_rst || !active)
        begin
            state_q <= TWS_IDLE;
            bit_cnt_q <= 3'h0;
            byte_full_q <= 1'b0;
            byte_idx_q <= `TWS_IDX_ADDR;
            dir_q <= 1'b0;
            rx_q <= 8'h00;
        end
        else if (start_det)
        begin
            // Also a repeated start: decoding restarts from the address
            state_q <= TWS_RECV;
            bit_cnt_q <= 3'h0;
            byte_full_q <= 1'b0;
            byte_idx_q <= `TWS_IDX_ADDR;
        end
        else if (stop_det)
        begin
            state_q <= TWS_IDLE;
        end
        else
        begin
            case (state_q)
                TWS_RECV:
                begin
                    if (scl_rise)
                    begin
                        rx_q <= {rx_q[6:0], sync_bus.sda};
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        byte_full_q <= (bit_cnt_q == `TWS_LAST_BIT);
                    end
                    else if (byte_end)
                    begin
                        byte_full_q <= 1'b0;
                        if (is_addr)
                        begin
                            dir_q <= rx_q[0];
                        end
                        if (is_addr && !addr_match)
                        begin
                            state_q <= TWS_SKIP;
                        end
                        else
                        begin
                            state_q <= TWS_ACK;
                        end
                        if (byte_idx_q != `TWS_IDX_DATA)
                        begin
                            byte_idx_q <= byte_idx_q + 2'h1;
                        end
                    end
                end
                TWS_ACK:
                begin
                    if (scl_fall)
                    begin
                        state_q <= dir_q ? TWS_SEND : TWS_RECV;
                        bit_cnt_q <= 3'h0;
                    end
                end
                TWS_SEND:
                begin
                    if (scl_fall)
                    begin
                        bit_cnt_q <= bit_cnt_q + 3'h1;
                        if (bit_cnt_q == `TWS_LAST_BIT)
                        begin
                            state_q <= TWS_MACK;
                        end
                    end
                end
                TWS_MACK:
                begin
                    if (scl_rise && sync_bus.sda)
                    begin
                        state_q <= TWS_SKIP;
                    end
                    else if (scl_fall)
                    begin
                        state_q <= TWS_SEND;
                        bit_cnt_q <= 3'h0;
                    end
                end
                TWS_IDLE, TWS_SKIP:
                begin
                    state_q <= state_q;
                end
                default:
                begin
                    state_q <= TWS_IDLE;
                end
            endcase
        end
    end

    // Open-drain SDA: only acks and read data bits ever pull low
    always_ff @(posedge clk)
    begin
        if (sys_rst || !active || start_det || stop_det)
        begin
            sda_oe_n_q <= 1'b1;
        end
        else if (byte_end && !(is_addr && !addr_match))
        begin
            sda_oe_n_q <= 1'b0;
        end
        else if (state_q == TWS_ACK && scl_fall)
        begin
            sda_oe_n_q <= dir_q ? tx_q[7] : 1'b1;
        end
        else if (state_q == TWS_SEND && scl_fall)
        begin
            // Released for the master's acknowledge after bit eight
            sda_oe_n_q <= tx_last ? 1'b1 : tx_q[6];
        end
        else if (state_q == TWS_MACK && scl_fall)
        begin
            sda_oe_n_q <= tx_q[7];
        end
        else if (state_q == TWS_SKIP || state_q == TWS_IDLE)
        begin
            sda_oe_n_q <= 1'b1;
        end
    end

    // Transmit shifter, loaded the cycle after each read request
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            tx_q <= 8'hFF;
        end
        else if (load_q)
        begin
            tx_q <= reg_rd_data;
        end
        else if (state_q == TWS_SEND && scl_fall)
        begin
            tx_q <= {tx_q[6:0], 1'b1};
        end
    end

    // Block, base address and colour component pointers
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            blk_q <= `TWS_BLK_CTRL;
            ptr_q <= 8'h00;
            color_q <= 2'h0;
        end
        else if (byte_end && !dir_q
            && byte_idx_q == `TWS_IDX_BLK)
        begin
            blk_q <= rx_q;
            color_q <= 2'h0;
        end
        else if (byte_end && !dir_q
            && byte_idx_q == `TWS_IDX_OFS)
        begin
            ptr_q <= rx_q;
            color_q <= 2'h0;
        end
        else if (adv_q || tx_last)
        begin
            if (blk_q == `TWS_BLK_CTRL)
            begin
                // Saturates rather than wrapping past the last register
                if (ptr_q != `TWS_CTRL_MAX)
                begin
                    ptr_q <= ptr_q + 8'h01;
                end
            end
            else if (blk_q == `TWS_BLK_TABLE)
            begin
                if (color_q == `TWS_LAST_COLOR)
                begin
                    color_q <= 2'h0;
                    ptr_q <= ptr_q + 8'h01;
                end
                else
                begin
                    color_q <= color_q + 2'h1;
                end
            end
        end
    end

    // Access strobes; pointer moves the cycle after a write strobe
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            reg_wr_en_q <= 1'b0;
            reg_rd_en_q <= 1'b0;
            reg_wr_data_q <= 8'h00;
            adv_q <= 1'b0;
            load_q <= 1'b0;
        end
        else
        begin
            reg_wr_en_q <= wr_data & block_ok;
            adv_q <= wr_data;
            reg_rd_en_q <= rd_first | mack_ok;
            load_q <= reg_rd_en_q;
            if (wr_data)
            begin
                reg_wr_data_q <= rx_q;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = sda_oe_n_q;
    assign reg_wr_en = reg_wr_en_q;
    assign reg_rd_en = reg_rd_en_q;
    assign reg_block = blk_q[0];
    assign reg_addr = ptr_q;
    assign color_sel = color_q;
    assign reg_wr_data = reg_wr_data_q;
endmodule

// [logic/tws_sync.sv]
// Purpose: Two-flop synchroniser for all pins entering the clk domain
// Assumes: sys_rst synchronous, active high
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_sync
    import tws_pkg::*;
#(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RST_VAL = `TWS_SYNC_IDLE
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Raw pins
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic port_sel_n_pin,
    input wire logic [1:0] addr_sel_pin,
    // Synchronised levels
    tws_sync_if.src sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // Both stages reset to the idle level so no false start appears
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            meta_q <= RST_VAL;
            sync_q <= RST_VAL;
        end
        else
        begin
            meta_q <= {scl_pin, sda_pin, port_sel_n_pin, addr_sel_pin};
            sync_q <= meta_q;
        end
    end

    assign sync.scl = sync_q[4];
    assign sync.sda = sync_q[3];
    assign sync.port_sel_n = sync_q[2];
    assign sync.addr_sel = sync_q[1:0];
endmodule

// [logic/tws_sync_if.sv]
// Purpose: Synchronised pin levels passed from the synchroniser
// Assumes: Single clock domain on the receiving side
// Notes: Carries levels only, never raw pins
`timescale 1ns/1ps
interface tws_sync_if;
    logic scl;
    logic sda;
    logic port_sel_n;
    logic [1:0] addr_sel;

    modport src
    (
        output scl,
        output sda,
        output port_sel_n,
        output addr_sel
    );
    modport dst
    (
        input scl,
        input sda,
        input port_sel_n,
        input addr_sel
    );
endinterface

// [sim/test_two_wire_control_slave.sv]
// Purpose: Self-checking bench for the two-wire control slave
// Assumes: Register file answers with address xor A5
// Notes: Writes are logged from the strobe and compared per scenario
`timescale 1ns/1ps
`include "tws_params.svh"
module test_two_wire_control_slave
    import tws_pkg::*;
;
    localparam logic [1:0] SEL = 2'h2;
    localparam tws_byte_t AW = {`TWS_ADDR_HI, SEL, 1'b0};
    localparam tws_byte_t AR = {`TWS_ADDR_HI, SEL, 1'b1};
    logic clk, sys_rst, scl, m_sda, sda_wire, port_sel_n;
    logic sda_out, sda_oe_n, reg_wr_en, reg_rd_en, reg_block;
    logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
    logic [1:0] color_sel;
    logic [1:0] addr_pins;
    logic [18:0] wq[$];
    int fail_count, compares;
    int rd_count = 0;

    // Pull-up: the wire is low only while someone pulls it
    assign sda_wire = m_sda & (sda_oe_n | sda_out);

    tws_slave u_tws_slave (.clk(clk), .sys_rst(sys_rst), .scl_in(scl),
        .sda_in(sda_wire), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .port_sel_n(port_sel_n), .address_select_pins(addr_pins),
        .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_block(reg_block), .reg_addr(reg_addr),
        .color_sel(color_sel), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data));
    tws_master_model u_tws_master_model (.clk(clk), .sda(sda_wire),
        .scl(scl), .sda_drv(m_sda));

    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    always @(negedge clk)
    begin
        if (reg_rd_en === 1'b1)
        begin
            reg_rd_data <= reg_addr ^ 8'hA5;
            rd_count++;
        end
        if (reg_wr_en === 1'b1)
            wq.push_back({reg_block, color_sel, reg_addr, reg_wr_data});
    end

    task check(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task send(input tws_byte_t d, input logic exp_ack);
        logic a;
        u_tws_master_model.wr_byte(d, a);
        check("ack", a, exp_ack);
    endtask

    task get(input logic ack_it, input tws_byte_t exp);
        tws_byte_t d;
        u_tws_master_model.rd_byte(ack_it, d);
        check("read data", d, exp);
    endtask

    task print_verdict;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task t_ctrl_write;
        tws_byte_t a;
        wq.delete();
        u_tws_master_model.start();
        send(AW, 1'b1);
        send(`TWS_BLK_CTRL, 1'b1);
        send(8'h4A, 1'b1);
        for (int i = 0; i < 4; i++)
            send(8'(8'hC0 + i), 1'b1);
        u_tws_master_model.stop();
        check("write count", wq.size(), 4);
        for (int i = 0; i < 4; i++)
        begin
            a = (i < 3) ? 8'(8'h4A + i) : `TWS_CTRL_MAX;
            check("ctrl write", wq[i], {3'h0, a, 8'(8'hC0 + i)});
        end
    endtask

    task t_table_write;
        wq.delete();
        u_tws_master_model.start();
        send(AW, 1'b1);
        send(`TWS_BLK_TABLE, 1'b1);
        send(8'hFF, 1'b1);
        for (int i = 0; i < 6; i++)
            send(8'(8'h30 + i), 1'b1);
        u_tws_master_model.stop();
        check("write count", wq.size(), 6);
        for (int i = 0; i < 6; i++)
            check("table write", wq[i], {1'b1, 2'(i % 3),
                8'(8'hFF + i / 3), 8'(8'h30 + i)});
    endtask

    task t_read;
        int n0;
        n0 = rd_count;
        u_tws_master_model.start();
        send(AW, 1'b1);
        send(`TWS_BLK_CTRL, 1'b1);
        send(8'h4B, 1'b1);
        u_tws_master_model.start();
        send(AR, 1'b1);
        get(1'b1, 8'h4B ^ 8'hA5);
        get(1'b1, 8'h4C ^ 8'hA5);
        get(1'b0, 8'h4C ^ 8'hA5);
        repeat (6) @(negedge clk);
        check("sda released", sda_oe_n, 1'b1);
        // A nack must not fetch a fourth byte
        check("read requests", rd_count - n0, 3);
        u_tws_master_model.stop();
    endtask

    task t_mismatch;
        wq.delete();
        for (int i = 0; i < 2; i++)
        begin
            u_tws_master_model.start();
            send(i ? {5'h14, SEL, 1'b0} : {`TWS_ADDR_HI, ~SEL, 1'b0},
                1'b0);
            send(8'h00, 1'b0);
            u_tws_master_model.stop();
        end
        // Pins now match the other address; an unknown block is never written
        addr_pins = ~SEL;
        repeat (5) @(negedge clk);
        u_tws_master_model.start();
        send({`TWS_ADDR_HI, ~SEL, 1'b0}, 1'b1);
        send(8'h02, 1'b1);
        send(8'h00, 1'b1);
        send(8'h5A, 1'b1);
        u_tws_master_model.stop();
        addr_pins = SEL;
        repeat (5) @(negedge clk);
        check("ignored writes", wq.size(), 0);
    endtask

    task t_port_dead;
        wq.delete();
        port_sel_n = 1'b1;
        repeat (5) @(negedge clk);
        u_tws_master_model.start();
        send(AW, 1'b0);
        send(`TWS_BLK_CTRL, 1'b0);
        send(8'h10, 1'b0);
        send(8'h77, 1'b0);
        u_tws_master_model.stop();
        check("dead port writes", wq.size(), 0);
        port_sel_n = 1'b0;
        repeat (5) @(negedge clk);
    endtask

    // Hang guard
    initial
    begin
        repeat (50000) @(posedge clk);
        fail_count++;
        print_verdict;
    end

    initial
    begin
        sys_rst = 1'b1;
        port_sel_n = 1'b0;
        addr_pins = SEL;
        fail_count = 0;
        compares = 0;
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (5) @(negedge clk);
        t_ctrl_write;
        t_table_write;
        t_read;
        t_mismatch;
        t_port_dead;
        t_ctrl_write;
        print_verdict;
    end
endmodule

// [sim/tws_master_model.sv]
// Purpose: Behavioural two-wire bus master
// Assumes: Changes pins on falling clk edges, 80 ns SCL period
// Notes: sda_drv high means released; SCL stands high between frames
`timescale 1ns/1ps
module tws_master_model
    import tws_pkg::*;
(
    // Clock and bus
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    initial
    begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task wait_clk(input int n);
        repeat (n) @(negedge clk);
    endtask

    // Leaves SCL low; also serves as repeated start
    task start();
        wait_clk(2);
        sda_drv = 1'b1;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(5);
        sda_drv = 1'b0;
        wait_clk(5);
        scl = 1'b0;
    endtask

    task stop();
        wait_clk(2);
        sda_drv = 1'b0;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(5);
        sda_drv = 1'b1;
        wait_clk(5);
    endtask

    task xfer_bit(input logic b, output logic r);
        wait_clk(2);
        sda_drv = b;
        wait_clk(3);
        scl = 1'b1;
        wait_clk(3);
        r = sda;
        wait_clk(2);
        scl = 1'b0;
    endtask

    task wr_byte(input tws_byte_t d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = !r;
    endtask

    task rd_byte(input logic ack_it, output tws_byte_t d);
        logic r;
        for (int i = 7; i >= 0; i--)
            xfer_bit(1'b1, d[i]);
        xfer_bit(!ack_it, r);
    endtask
endmodule

// [sim/tws_slave_sva.sv]
// Purpose: Port assertions for the two-wire control slave
// Assumes: clk far faster than SCL, pins idle high at reset release
// Notes: Bound to every tws_slave instance
`timescale 1ns/1ps
`include "tws_params.svh"
module tws_slave_sva
    import tws_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic port_sel_n,
    // Register side
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic reg_block,
    input wire logic [7:0] reg_addr,
    input wire logic [1:0] color_sel
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    a_drive_zero: assert property (sda_out == 1'b0)
        else $error("sda drive value is not low");
    a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda drive changed while scl high");
    a_wr_spacing: assert property (reg_wr_en |=> !reg_wr_en [*8])
        else $error("write strobes too close");
    a_ctrl_inc: assert property (reg_wr_en && !reg_block
        && reg_addr < `TWS_CTRL_MAX |=> reg_addr == $past(reg_addr) + 8'h01)
        else $error("control address did not advance");
    a_ctrl_sat: assert property (reg_wr_en && !reg_block
        && reg_addr == `TWS_CTRL_MAX |=> reg_addr == `TWS_CTRL_MAX)
        else $error("control address left its maximum");
    a_tab_comp: assert property (reg_wr_en && reg_block
        && color_sel != `TWS_LAST_COLOR
        |=> color_sel == $past(color_sel) + 2'h1 && $stable(reg_addr))
        else $error("table component did not step");
    a_tab_loc: assert property (reg_wr_en && reg_block
        && color_sel == `TWS_LAST_COLOR
        |=> color_sel == 2'h0 && reg_addr == $past(reg_addr) + 8'h01)
        else $error("table location did not advance");
    a_port_dead: assert property (port_sel_n [*5]
        |-> sda_oe_n && !reg_wr_en && !reg_rd_en)
        else $error("serial port active while deselected");
    a_rd_pulse: assert property (reg_rd_en |=> !reg_rd_en [*8])
        else $error("read requests too close");

    c_ctrl_wr: cover property (reg_wr_en && !reg_block);
    c_tab_wr: cover property (reg_wr_en && reg_block && color_sel == 2'h2);
    c_rd: cover property (reg_rd_en);
endmodule

bind tws_slave tws_slave_sva u_tws_slave_sva (.clk, .sys_rst, .scl_in,
    .sda_out, .sda_oe_n, .port_sel_n, .reg_wr_en, .reg_rd_en, .reg_block,
    .reg_addr, .color_sel);
